// [pioc_bank.v]
/*
 * one io bank of programmable io cells with a classic wishbone
 * register slave for cell configuration and bank-wide freeze.
 * assumes rst_i is the power-on reset and all inputs are
 * synchronous to clk_i; register and clock enables are pulses or
 * levels sampled on clk_i.
 */
// Added by the designer: register access over Wishbone and the address map.
// What this block does
// - each cell has an input capture stage, an output data stage and a tri-state control stage.
// - while freeze is on, an unregistered input holds its last value so pad changes stop reaching the core.
// - one freeze control serves every cell of the bank.
// - a per-cell latch control holds the value presented to the core while asserted.
// - pad inputs can be captured on the input register enable before reaching the core.
// - output data is either registered on the output register enable or passed straight to the pad.
// - before configuration every pad is high impedance with its weak pull-up on.
// - pads take user settings only after power-on reset release and a finished configuration load.
// - the core side stays idle during power-on reset and runs only after its release.
// - unused pads are blocked and their pull-up is off after configuration.
// - each pad has its own pull-up or no-maintenance choice.
// - registered inputs ignore freeze and hold through their own enables.
`timescale 1ns/1ns
`include "pioc_defs.vh"
module pioc_bank #(
   parameter N = 8
) (
   // clock and reset
   input wire clk_i,
   input wire rst_i,
   // wishbone slave
   input wire cyc_i,
   input wire stb_i,
   input wire we_i,
   input wire [7:0] adr_i,
   input wire [3:0] sel_i,
   input wire [31:0] dat_i,
   output wire [31:0] dat_o,
   output wire ack_o,
   // shared cell enables
   input wire clk_en_i,
   input wire in_clk_en_i,
   input wire out_clk_en_i,
   // core side
   input wire [N-1:0] core_dout_i,
   input wire [N-1:0] core_oe_i,
   input wire [N-1:0] core_latch_i,
   output wire [N-1:0] core_din_o,
   // pad side
   input wire [N-1:0] pad_i,
   output wire [N-1:0] pad_o,
   output wire [N-1:0] pad_oe_o,
   output wire [N-1:0] pad_pu_o
);

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   reg ack_q;
   reg [31:0] dat_q;
   reg [31:0] rd_d;
   wire req;
   wire wr;
   wire [7:0] adr;
   wire [31:0] bmask;

   assign req = cyc_i & stb_i & ~ack_q;
   assign wr = req & we_i;
   assign adr = {adr_i[7:2], 2'b00};
   assign bmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
   assign ack_o = ack_q;
   assign dat_o = dat_q;

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   reg configured_q;
   reg freeze_q;
   reg [N-1:0] used_q;
   reg [N-1:0] ireg_q;
   reg [N-1:0] oreg_q;
   reg [N-1:0] oereg_q;
   reg [N-1:0] pull_q;
   wire [31:0] rst_mask;
   wire [31:0] rst_pull;

   assign rst_mask = `PIOC_RST_MASK;
   assign rst_pull = `PIOC_RST_PULL;

   function [N-1:0] merge;
      input [N-1:0] old;
      input [31:0] wdat;
      input [31:0] m;
      begin
         merge = (old & ~m[N-1:0]) | (wdat[N-1:0] & m[N-1:0]);
      end
   endfunction

   always @(posedge clk_i) begin
      if (rst_i) begin
         configured_q <= 1'b0;
         freeze_q <= 1'b0;
         used_q <= rst_mask[N-1:0];
         ireg_q <= rst_mask[N-1:0];
         oreg_q <= rst_mask[N-1:0];
         oereg_q <= rst_mask[N-1:0];
         pull_q <= rst_pull[N-1:0];
      end else if (wr) begin
         case (adr)
            `PIOC_ADR_CTRL: begin
               if (sel_i[0]) begin
                  // load completes once and stays until power-on reset
                  if (dat_i[`PIOC_CTRL_DONE]) begin
                     configured_q <= 1'b1;
                  end
                  freeze_q <= dat_i[`PIOC_CTRL_FREEZE];
               end
            end
            `PIOC_ADR_USED: begin
               used_q <= merge(used_q, dat_i, bmask);
            end
            `PIOC_ADR_IREG: begin
               ireg_q <= merge(ireg_q, dat_i, bmask);
            end
            `PIOC_ADR_OREG: begin
               oreg_q <= merge(oreg_q, dat_i, bmask);
            end
            `PIOC_ADR_OEREG: begin
               oereg_q <= merge(oereg_q, dat_i, bmask);
            end
            `PIOC_ADR_PULL: begin
               pull_q <= merge(pull_q, dat_i, bmask);
            end
            default: begin
               configured_q <= configured_q;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // read mux
   // ----------------------------------------------------------------
   always @* begin
      rd_d = 32'h00000000;
      case (adr)
         `PIOC_ADR_CTRL: begin
            rd_d[`PIOC_CTRL_DONE] = configured_q;
            rd_d[`PIOC_CTRL_FREEZE] = freeze_q;
         end
         `PIOC_ADR_USED: begin
            rd_d[N-1:0] = used_q;
         end
         `PIOC_ADR_IREG: begin
            rd_d[N-1:0] = ireg_q;
         end
         `PIOC_ADR_OREG: begin
            rd_d[N-1:0] = oreg_q;
         end
         `PIOC_ADR_OEREG: begin
            rd_d[N-1:0] = oereg_q;
         end
         `PIOC_ADR_PULL: begin
            rd_d[N-1:0] = pull_q;
         end
         `PIOC_ADR_PADIN: begin
            rd_d[N-1:0] = pad_i;
         end
         `PIOC_ADR_STAT: begin
            rd_d[`PIOC_STAT_CONFIGURED] = configured_q;
            rd_d[`PIOC_STAT_FREEZE] = freeze_q;
         end
         default: begin
            rd_d = 32'h00000000;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // acknowledge and read data
   // ----------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         dat_q <= 32'h00000000;
      end else begin
         ack_q <= req;
         if (req & ~we_i) begin
            dat_q <= rd_d;
         end
      end
   end

   // ----------------------------------------------------------------
   // cells
   // ----------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < N; i = i + 1) begin : g_cell
         pioc_cell u_cell (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .configured_i(configured_q),
            .freeze_i(freeze_q),
            .clk_en_i(clk_en_i),
            .in_clk_en_i(in_clk_en_i),
            .out_clk_en_i(out_clk_en_i),
            .used_i(used_q[i]),
            .ireg_i(ireg_q[i]),
            .oreg_i(oreg_q[i]),
            .oereg_i(oereg_q[i]),
            .pull_i(pull_q[i]),
            .dout_i(core_dout_i[i]),
            .oe_i(core_oe_i[i]),
            .latch_i(core_latch_i[i]),
            .din_o(core_din_o[i]),
            .pad_i(pad_i[i]),
            .pad_o(pad_o[i]),
            .pad_oe_o(pad_oe_o[i]),
            .pad_pu_o(pad_pu_o[i])
         );
      end
   endgenerate

endmodule

// [pioc_defs.vh]
/*
 * register offsets, field positions, reset values and bus constants
 * for the programmable io bank.
 * assumes a 32-bit classic wishbone slave with byte addresses.
 */
`ifndef PIOC_DEFS_VH
`define PIOC_DEFS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define PIOC_ADR_CTRL 8'h00
`define PIOC_ADR_USED 8'h04
`define PIOC_ADR_IREG 8'h08
`define PIOC_ADR_OREG 8'h0c
`define PIOC_ADR_OEREG 8'h10
`define PIOC_ADR_PULL 8'h14
`define PIOC_ADR_PADIN 8'h18
`define PIOC_ADR_STAT 8'h1c

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PIOC_CTRL_DONE 0
`define PIOC_CTRL_FREEZE 1
`define PIOC_STAT_CONFIGURED 0
`define PIOC_STAT_FREEZE 1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PIOC_RST_MASK 32'h00000000
`define PIOC_RST_PULL 32'hffffffff

`endif

// [pioc_cell.v]
/*
 * one programmable io cell: input, output and tri-state register
 * stages, freeze and latch holds, pre-configuration pad state.
 * assumes pad and core signals are synchronous to clk_i.
 */
`timescale 1ns/1ns
module pioc_cell (
   // clock and reset
   input wire clk_i,
   input wire rst_i,
   // bank controls
   input wire configured_i,
   input wire freeze_i,
   input wire clk_en_i,
   input wire in_clk_en_i,
   input wire out_clk_en_i,
   // cell configuration
   input wire used_i,
   input wire ireg_i,
   input wire oreg_i,
   input wire oereg_i,
   input wire pull_i,
   // core side
   input wire dout_i,
   input wire oe_i,
   input wire latch_i,
   output wire din_o,
   // pad side
   input wire pad_i,
   output wire pad_o,
   output wire pad_oe_o,
   output wire pad_pu_o
);

   // ----------------------------------------------------------------
   // register stages
   // ----------------------------------------------------------------
   reg in_q;
   reg out_q;
   reg oe_q;
   reg frz_q;
   reg lat_q;
   wire din_raw;
   wire run;

   assign run = configured_i & used_i;

   always @(posedge clk_i) begin
      if (rst_i) begin
         in_q <= 1'b0;
         out_q <= 1'b0;
         oe_q <= 1'b0;
      end else begin
         if (clk_en_i & in_clk_en_i) begin
            in_q <= pad_i;
         end
         if (clk_en_i & out_clk_en_i) begin
            out_q <= dout_i;
            oe_q <= oe_i;
         end
      end
   end

   // ----------------------------------------------------------------
   // freeze and latch holds
   // ----------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         frz_q <= 1'b0;
         lat_q <= 1'b0;
      end else begin
         if (!freeze_i) begin
            frz_q <= pad_i;
         end
         if (!latch_i) begin
            lat_q <= din_raw;
         end
      end
   end

   // registered inputs bypass the freeze hold
   assign din_raw = ireg_i ? in_q : (freeze_i ? frz_q : pad_i);
   assign din_o = run & (latch_i ? lat_q : din_raw);

   // ----------------------------------------------------------------
   // pad drive
   // ----------------------------------------------------------------
   assign pad_o = run & (oreg_i ? out_q : dout_i);
   assign pad_oe_o = run & (oereg_i ? oe_q : oe_i);
   assign pad_pu_o = configured_i ? (used_i & pull_i) : 1'b1;

endmodule

// [pioc_bank_assertions.sv]
/* port checker for pioc_bank: bus answers and pad states
   assumes one clock, clk_i, with synchronous reset rst_i */
`timescale 1ns/1ns
module pioc_bank_assertions #(parameter N = 8) (
   input wire clk_i, rst_i, cyc_i, stb_i, we_i,
   input wire [7:0] adr_i,
   input wire [3:0] sel_i,
   input wire [31:0] dat_i, dat_o,
   input wire ack_o,
   input wire [N-1:0] pad_i, pad_oe_o, pad_pu_o, core_din_o
);
   reg cfg_q;
   wire tk = cyc_i && stb_i && !ack_o;
   wire rd = tk && !we_i;
   always @(posedge clk_i)
      if (rst_i) cfg_q <= 1'b0;
      else if (tk && we_i && adr_i[7:2] == 6'h0 && sel_i[0] && dat_i[0]) cfg_q <= 1'b1;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   AST_ACK_RESP: assert property (tk |=> ack_o) else $error("request not acked");
   AST_ACK_PULSE: assert property (ack_o |=> !ack_o) else $error("ack too long");
   AST_ACK_IDLE: assert property (!(cyc_i && stb_i) |=> !ack_o) else $error("stray ack");
   AST_RST_PADS: assert property (
      disable iff (1'b0) rst_i |=> pad_oe_o == '0 && pad_pu_o == '1 && core_din_o == '0)
      else $error("pads not safe in reset");
   AST_PRECFG_PADS: assert property (!cfg_q |-> pad_oe_o == '0 && pad_pu_o == '1)
      else $error("pad left precfg state");
   AST_PRECFG_DIN: assert property (!cfg_q |-> core_din_o == '0) else $error("core input before config");
   AST_UNMAPPED: assert property (rd && adr_i >= 8'h20 |=> dat_o == 32'h0) else $error("unmapped read");
   AST_STAT: assert property (rd && adr_i[7:2] == 6'h7 |=> dat_o[0] == cfg_q) else $error("status wrong");
   AST_PADIN: assert property (rd && adr_i[7:2] == 6'h6 |=> dat_o[N-1:0] == $past(pad_i))
      else $error("raw pad read wrong");
   cover property (tk && we_i && adr_i == 8'h00);
   cover property (rd && adr_i >= 8'h20);
   cover property (rd && adr_i == 8'h1c && cfg_q);
endmodule
bind pioc_bank pioc_bank_assertions #(.N(N)) pioc_bank_assertions_i (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
   .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .pad_i, .pad_oe_o, .pad_pu_o, .core_din_o);

// [pioc_pad_model.sv]
/* board side of the pads: resolves each pad wire level
   assumes the board drives only pads where ext_en_i is high */
`timescale 1ns/1ns
module pioc_pad_model #(parameter N = 8) (
   input wire clk_i,
   input wire [N-1:0] drv_i, oe_i, pu_i, ext_en_i, ext_val_i,
   output wire [N-1:0] lvl_o
);
   logic [N-1:0] wob_q = '0;
   always @(posedge clk_i) wob_q <= ~wob_q;
   // driven pads read back, pulled pads read high, floating pads wander
   assign lvl_o = (oe_i & drv_i) | (~oe_i & pu_i) | (~oe_i & ~pu_i & ((ext_en_i & ext_val_i) | (~ext_en_i & wob_q)));
endmodule

// [test_pioc_bank.sv]
/* self-checking bench for pioc_bank with the board pad model
   assumes eight pads and a one-cycle bus answer */
`timescale 1ns/1ns
module test_pioc_bank;
   logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, clk_en_i = 1, in_clk_en_i = 1, out_clk_en_i = 1;
   logic [7:0] adr_i = 0, dout = 0, oe = 8'hff, lat = 0, ext_en = 0, ext_val = 0, u, p, d0, d1, o2;
   logic [3:0] sel_i = 4'hf;
   logic [31:0] dat_i = 0;
   wire [31:0] dat_o;
   wire ack_o;
   wire [7:0] din, pad_i, pad_o, pad_oe, pad_pu;
   int miscompares = 0, checks_done = 0;
   logic [31:0] rdq[$], pq[$];
   event smp;
   pioc_bank pioc_bank_i (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
      .clk_en_i, .in_clk_en_i, .out_clk_en_i, .core_dout_i(dout), .core_oe_i(oe), .core_latch_i(lat),
      .core_din_o(din), .pad_i, .pad_o, .pad_oe_o(pad_oe), .pad_pu_o(pad_pu));
   pioc_pad_model pioc_pad_model_i (.clk_i, .drv_i(pad_o), .oe_i(pad_oe), .pu_i(pad_pu), .ext_en_i(ext_en),
      .ext_val_i(ext_val), .lvl_o(pad_i));
   task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
      int n;
      n = 0;
      {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 20);
      if (n >= 20) begin
         miscompares++;
         print_verdict();
      end else begin
         {cyc_i, stb_i} <= 2'b00;
         @(posedge clk_i);
      end
   endtask
   task automatic rd(logic [7:0] a, logic [31:0] e);
      rdq.push_back(e);
      wb(0, a, 0);
   endtask
   task automatic pads(logic [7:0] di, po, o, pu);
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
      pq.push_back({di, po & o, o, pu});
      -> smp;
      @(posedge clk_i);
   endtask
   always @(posedge clk_i)
      if (ack_o === 1'b1 && we_i === 1'b0) check("dat_o", dat_o, rdq.pop_front());
   always @(smp) begin
      logic [31:0] e;
      e = pq.pop_front();
      check("core_din_o", {24'h0, din}, {24'h0, e[31:24]});
      check("pad_o", {24'h0, pad_o & pad_oe}, {24'h0, e[23:16]});
      check("pad_oe_o", {24'h0, pad_oe}, {24'h0, e[15:8]});
      check("pad_pu_o", {24'h0, pad_pu}, {24'h0, e[7:0]});
   end
   initial begin
      forever #10 clk_i = ~clk_i;
   end
   initial begin
      void'($urandom(32'h529790b4));
      u = 8'($urandom) | 8'h81;
      p = 8'($urandom);
      d0 = 8'($urandom);
      d1 = ~d0;
      ext_val <= 8'($urandom);
      ext_en <= ~u;
      dout <= d0;
      repeat (10) @(posedge clk_i);
      rst_i <= 0;
      pads(0, 0, 0, 8'hff);
      wb(1, 8'h04, u);
      wb(1, 8'h14, p);
      wb(1, 8'h08, 32'h0f);
      pads(0, 0, 0, 8'hff);
      rd(8'h1c, 0);
      wb(1, 8'h00, 1);
      rd(8'h1c, 1);
      rd(8'h20, 0);
      rd(8'h14, p);
      rd(8'h18, (u & d0) | (~u & ext_val));
      pads(u & d0, d0, u, u & p);
      in_clk_en_i <= 0;
      dout <= d1;
      pads(u & ((d1 & 8'hf0) | (d0 & 8'h0f)), d1, u, u & p);
      in_clk_en_i <= 1;
      wb(1, 8'h0c, 32'hff);
      out_clk_en_i <= 0;
      dout <= d0;
      pads(u & d1, d1, u, u & p);
      {clk_en_i, out_clk_en_i} <= 2'b01;
      pads(u & d1, d1, u, u & p);
      clk_en_i <= 1;
      pads(u & d0, d0, u, u & p);
      wb(1, 8'h0c, 0);
      wb(1, 8'h00, 3);
      dout <= d1;
      pads(u & ((d0 & 8'hf0) | (d1 & 8'h0f)), d1, u, u & p);
      rd(8'h1c, 3);
      wb(1, 8'h00, 1);
      lat <= 8'hff;
      dout <= d0;
      pads(u & d1, d0, u, u & p);
      lat <= 0;
      pads(u & d0, d0, u, u & p);
      sel_i <= 4'he;
      wb(1, 8'h00, 2);
      wb(1, 8'h04, 0);
      sel_i <= 4'hf;
      rd(8'h1c, 1);
      rd(8'h04, u);
      o2 = 8'($urandom);
      wb(1, 8'h10, 32'hff);
      ext_en <= 8'hff;
      oe <= o2;
      pads(u & ((o2 & d0) | (~o2 & (p | ext_val))), d0, u & o2, u & p);
      out_clk_en_i <= 0;
      oe <= ~o2;
      pads(u & ((o2 & d0) | (~o2 & (p | ext_val))), d0, u & o2, u & p);
      out_clk_en_i <= 1;
      rst_i <= 1;
      repeat (2) @(posedge clk_i);
      rst_i <= 0;
      pads(0, 0, 0, 8'hff);
      rd(8'h1c, 0);
      print_verdict();
   end
endmodule
